// *** verilog/amp_control_clock_fault_regs.sv ***
// amp control register bank with two clock-fault detectors on axi4-lite
// ------------------------------------------------------------------
// Functional notes
// R1: spread-spectrum bit 0 enables modulator spreading, only with internal ramp clock.
// R2: second input channel bits 4-3: left, right, average, mono pcm.
// R3: first input channel bits 2-1: left, right, average, mono pcm.
// R4: mute soft-step bit 0 low steps level on mute; high disables.
// R5: boost current limit bits 1-0 pick 1.5 to 3.0 A; resets to 3.
// R6: block one fault mutes by hardware sequence at 0, processor sequence at 1.
// R7: block one watches first serial clock at 0, second at 1.
// R8: block two clock select: dac, adc, pll modulator clock; 3 reserved.
// R9: block one detection active only while control bit 1 is set.
// R10: block two detection active only while control bit 0 is set.
// R11: block one timeout expiry shuts down and raises power fault; reset code 7.
// R12: block two same behaviour with own timeout field, reset code 0.
// R13: recovery-off bit clear lets device recover automatically after fault.
// R14: timeout count restarts on each watched edge; fault when limit reached.
// ------------------------------------------------------------------
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
module amp_control_clock_fault_regs #(
   parameter int unsigned TIMEOUT_CYC [8] = amp_regs_pkg::TIMEOUT_CYC_DEF
) (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst,
   // axi4-lite write address
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [11:0] i_awaddr,
   input wire logic [2:0] i_awprot,
   // axi4-lite write data
   input wire logic i_wvalid,
   output logic o_wready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   // axi4-lite write response
   output logic o_bvalid,
   input wire logic i_bready,
   output logic [1:0] o_bresp,
   // axi4-lite read address
   input wire logic i_arvalid,
   output logic o_arready,
   input wire logic [11:0] i_araddr,
   input wire logic [2:0] i_arprot,
   // axi4-lite read data
   output logic o_rvalid,
   input wire logic i_rready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   // watched clocks, asynchronous
   input wire logic i_first_serial_input_clk,
   input wire logic i_second_serial_input_clk,
   input wire logic i_dac_mod_clk,
   input wire logic i_adc_mod_clk,
   input wire logic i_pll_clk,
   // modulator status, same clock domain
   input wire logic i_ramp_clk_internal,
   // audio path controls
   output logic o_spread_spectrum_on,
   output logic [1:0] o_first_input_channel_sel,
   output logic [1:0] o_second_input_channel_sel,
   output logic o_mute_soft_step_on,
   output logic [1:0] o_boost_current_limit,
   output logic o_processor_reset_mode,
   // fault handling
   output logic o_hw_mute_seq,
   output logic o_dsp_mute_seq,
   output logic o_shutdown,
   output logic o_power_fault_flag,
   output logic o_irq
);

   logic [7:0] spread_q;
   logic [7:0] mix_mute_q;
   logic [7:0] boost_q;
   logic [7:0] fault_ctl_q;
   logic [7:0] timeout_one_q;
   logic [7:0] timeout_two_q;
   logic [7:0] recovery_q;
   logic [2:0] irq_status_q;
   logic [2:0] irq_mask_q;

   logic aw_have_q;
   logic w_have_q;
   logic [9:0] aw_idx_q;
   logic [7:0] w_byte_q;
   logic w_lane_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;
   logic wr_fire;
   logic wr_hit;
   logic wr_en;
   logic [9:0] ar_idx;
   logic [7:0] rd_byte;
   logic rd_hit;

   logic fault_one;
   logic fault_two;
   logic set_one;
   logic set_two;
   logic rec_one;
   logic rec_two;
   logic mon_one_clk;
   logic mon_two_clk;
   logic two_sel_valid;
   logic [amp_regs_pkg::TIMER_W-1:0] limit_one;
   logic [amp_regs_pkg::TIMER_W-1:0] limit_two;
   logic [2:0] irq_events;
   logic spread_on_q;
   logic power_fault_q;

   // ----------------------------------------------------------------
   // axi4-lite write channel
   // ----------------------------------------------------------------
   // address and data are taken in either order, one write in flight
   assign o_awready = !aw_have_q && !bvalid_q;
   assign o_wready = !w_have_q && !bvalid_q;
   assign wr_fire = aw_have_q && w_have_q && !bvalid_q;

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         aw_have_q <= 1'b0;
         aw_idx_q <= '0;
      end else if (i_awvalid && o_awready) begin
         aw_have_q <= 1'b1;
         aw_idx_q <= i_awaddr[11:2];
      end else if (wr_fire) begin
         aw_have_q <= 1'b0;
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         w_have_q <= 1'b0;
         w_byte_q <= '0;
         w_lane_q <= 1'b0;
      end else if (i_wvalid && o_wready) begin
         w_have_q <= 1'b1;
         w_byte_q <= i_wdata[7:0];
         w_lane_q <= i_wstrb[0];
      end else if (wr_fire) begin
         w_have_q <= 1'b0;
      end
   end

   always_comb begin
      case (aw_idx_q)
         amp_regs_pkg::IDX_SPREAD_SPECTRUM,
         amp_regs_pkg::IDX_INPUT_MIX_MUTE,
         amp_regs_pkg::IDX_BOOST_LIMIT,
         amp_regs_pkg::IDX_FAULT_CONTROL,
         amp_regs_pkg::IDX_FAULT_TIMEOUT_ONE,
         amp_regs_pkg::IDX_FAULT_TIMEOUT_TWO,
         amp_regs_pkg::IDX_FAULT_RECOVERY,
         amp_regs_pkg::IDX_FAULT_STATE,
         amp_regs_pkg::IDX_IRQ_STATUS,
         amp_regs_pkg::IDX_IRQ_MASK: wr_hit = 1'b1;
         default: wr_hit = 1'b0;
      endcase
   end

   // a cleared lane-0 strobe leaves the byte untouched
   assign wr_en = wr_fire && wr_hit && w_lane_q;

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         bvalid_q <= 1'b0;
         bresp_q <= amp_regs_pkg::RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_q <= 1'b1;
         bresp_q <= wr_hit ? amp_regs_pkg::RESP_OKAY :
            amp_regs_pkg::RESP_SLVERR;
      end else if (bvalid_q && i_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   assign o_bvalid = bvalid_q;
   assign o_bresp = bresp_q;

   // ----------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         spread_q <= amp_regs_pkg::RST_SPREAD_SPECTRUM;
         mix_mute_q <= amp_regs_pkg::RST_INPUT_MIX_MUTE;
         boost_q <= amp_regs_pkg::RST_BOOST_LIMIT; // [R5]
      end else if (wr_en) begin
         case (aw_idx_q)
            amp_regs_pkg::IDX_SPREAD_SPECTRUM: spread_q <= w_byte_q;
            amp_regs_pkg::IDX_INPUT_MIX_MUTE: mix_mute_q <= w_byte_q;
            amp_regs_pkg::IDX_BOOST_LIMIT: boost_q <= w_byte_q;
            default: ;
         endcase
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         fault_ctl_q <= amp_regs_pkg::RST_FAULT_CONTROL;
         timeout_one_q <= amp_regs_pkg::RST_FAULT_TIMEOUT_ONE; // [R11]
         timeout_two_q <= amp_regs_pkg::RST_FAULT_TIMEOUT_TWO; // [R12]
         recovery_q <= amp_regs_pkg::RST_FAULT_RECOVERY;
      end else if (wr_en) begin
         case (aw_idx_q)
            amp_regs_pkg::IDX_FAULT_CONTROL: fault_ctl_q <= w_byte_q;
            amp_regs_pkg::IDX_FAULT_TIMEOUT_ONE: timeout_one_q <= w_byte_q;
            amp_regs_pkg::IDX_FAULT_TIMEOUT_TWO: timeout_two_q <= w_byte_q;
            amp_regs_pkg::IDX_FAULT_RECOVERY: recovery_q <= w_byte_q;
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // interrupt status and mask
   // ----------------------------------------------------------------
   assign irq_events = {rec_one | rec_two, set_two, set_one};

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         irq_status_q <= amp_regs_pkg::RST_IRQ;
      end else if (wr_en && aw_idx_q == amp_regs_pkg::IDX_IRQ_STATUS) begin
         // an event in the clearing cycle survives the write
         irq_status_q <= (irq_status_q & ~w_byte_q[2:0]) | irq_events;
      end else begin
         irq_status_q <= irq_status_q | irq_events;
      end
   end

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         irq_mask_q <= amp_regs_pkg::RST_IRQ;
      end else if (wr_en && aw_idx_q == amp_regs_pkg::IDX_IRQ_MASK) begin
         irq_mask_q <= w_byte_q[2:0];
      end
   end

   assign o_irq = |(irq_status_q & irq_mask_q);

   // ----------------------------------------------------------------
   // axi4-lite read channel
   // ----------------------------------------------------------------
   assign o_arready = !rvalid_q;
   assign ar_idx = i_araddr[11:2];

   always_comb begin
      rd_hit = 1'b1;
      case (ar_idx)
         amp_regs_pkg::IDX_SPREAD_SPECTRUM: rd_byte = spread_q;
         amp_regs_pkg::IDX_INPUT_MIX_MUTE: rd_byte = mix_mute_q;
         amp_regs_pkg::IDX_BOOST_LIMIT: rd_byte = boost_q;
         amp_regs_pkg::IDX_FAULT_CONTROL: rd_byte = fault_ctl_q;
         amp_regs_pkg::IDX_FAULT_TIMEOUT_ONE: rd_byte = timeout_one_q;
         amp_regs_pkg::IDX_FAULT_TIMEOUT_TWO: rd_byte = timeout_two_q;
         amp_regs_pkg::IDX_FAULT_RECOVERY: rd_byte = recovery_q;
         amp_regs_pkg::IDX_FAULT_STATE:
            rd_byte = {5'h00, power_fault_q, fault_two, fault_one};
         amp_regs_pkg::IDX_IRQ_STATUS: rd_byte = {5'h00, irq_status_q};
         amp_regs_pkg::IDX_IRQ_MASK: rd_byte = {5'h00, irq_mask_q};
         default: begin
            rd_byte = 8'h00;
            rd_hit = 1'b0;
         end
      endcase
   end

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         rvalid_q <= 1'b0;
         rdata_q <= '0;
         rresp_q <= amp_regs_pkg::RESP_OKAY;
      end else if (i_arvalid && o_arready) begin
         rvalid_q <= 1'b1;
         rdata_q <= {24'h000000, rd_byte};
         rresp_q <= rd_hit ? amp_regs_pkg::RESP_OKAY :
            amp_regs_pkg::RESP_SLVERR;
      end else if (rvalid_q && i_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   assign o_rvalid = rvalid_q;
   assign o_rdata = rdata_q;
   assign o_rresp = rresp_q;

   // ----------------------------------------------------------------
   // audio path controls
   // ----------------------------------------------------------------
   // spreading is meaningless against a synchronised ramp clock
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         spread_on_q <= 1'b0;
      end else begin
         spread_on_q <= spread_q[amp_regs_pkg::SPREAD_ON_BIT] &&
            i_ramp_clk_internal; // [R1]
      end
   end

   assign o_spread_spectrum_on = spread_on_q;
   assign o_second_input_channel_sel =
      mix_mute_q[amp_regs_pkg::SECOND_CH_LSB +: 2]; // [R2]
   assign o_first_input_channel_sel =
      mix_mute_q[amp_regs_pkg::FIRST_CH_LSB +: 2]; // [R3]
   assign o_mute_soft_step_on =
      !mix_mute_q[amp_regs_pkg::MUTE_SS_BIT]; // [R4]
   assign o_boost_current_limit =
      boost_q[amp_regs_pkg::BOOST_LIM_LSB +: 2]; // [R5]
   assign o_processor_reset_mode = fault_ctl_q[7];

   // ----------------------------------------------------------------
   // clock fault detection
   // ----------------------------------------------------------------
   assign mon_one_clk = fault_ctl_q[amp_regs_pkg::ONE_CLK_SEL_BIT] ?
      i_second_serial_input_clk : i_first_serial_input_clk; // [R7]

   // reserved select watches nothing and keeps block two idle
   always_comb begin
      two_sel_valid = 1'b1;
      case (fault_ctl_q[amp_regs_pkg::TWO_CLK_SEL_LSB +: 2])
         2'h0: mon_two_clk = i_dac_mod_clk; // [R8]
         2'h1: mon_two_clk = i_adc_mod_clk;
         2'h2: mon_two_clk = i_pll_clk;
         default: begin
            mon_two_clk = 1'b0;
            two_sel_valid = 1'b0;
         end
      endcase
   end

   assign limit_one = amp_regs_pkg::TIMER_W'(
      TIMEOUT_CYC[timeout_one_q[amp_regs_pkg::TIMEOUT_LSB +: 3]]); // [R11]
   assign limit_two = amp_regs_pkg::TIMER_W'(
      TIMEOUT_CYC[timeout_two_q[amp_regs_pkg::TIMEOUT_LSB +: 3]]); // [R12]

   clock_fault_detector u_fault_one (
      .i_sys_clk(i_sys_clk),
      .i_rst(i_rst),
      .i_enable(fault_ctl_q[amp_regs_pkg::ONE_ENABLE_BIT]), // [R9]
      .i_recovery_off(recovery_q[amp_regs_pkg::ONE_RECOVERY_OFF_BIT]),
      .i_limit(limit_one),
      .i_mon_clk(mon_one_clk),
      .o_fault(fault_one),
      .o_fault_set(set_one),
      .o_recover(rec_one)
   );

   clock_fault_detector u_fault_two (
      .i_sys_clk(i_sys_clk),
      .i_rst(i_rst),
      .i_enable(fault_ctl_q[amp_regs_pkg::TWO_ENABLE_BIT] &&
         two_sel_valid), // [R10]
      .i_recovery_off(recovery_q[amp_regs_pkg::TWO_RECOVERY_OFF_BIT]),
      .i_limit(limit_two),
      .i_mon_clk(mon_two_clk),
      .o_fault(fault_two),
      .o_fault_set(set_two),
      .o_recover(rec_two)
   );

   // ----------------------------------------------------------------
   // shutdown and mute
   // ----------------------------------------------------------------
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         power_fault_q <= 1'b0;
      end else begin
         power_fault_q <= fault_one || fault_two; // [R11] [R12]
      end
   end

   assign o_power_fault_flag = power_fault_q;
   assign o_shutdown = power_fault_q;
   assign o_hw_mute_seq = fault_one &&
      !fault_ctl_q[amp_regs_pkg::ONE_MUTE_METHOD_BIT]; // [R6]
   assign o_dsp_mute_seq = fault_one &&
      fault_ctl_q[amp_regs_pkg::ONE_MUTE_METHOD_BIT]; // [R6]

endmodule // amp_control_clock_fault_regs

// *** inc/amp_regs_pkg.sv ***
// register map, field layout and timing constants of the amp control bank
package amp_regs_pkg;

   // ----------------------------------------------------------------
   // register indices (byte address is four times the index)
   // ----------------------------------------------------------------
   localparam logic [9:0] IDX_SPREAD_SPECTRUM = 10'h028;
   localparam logic [9:0] IDX_INPUT_MIX_MUTE = 10'h02A;
   localparam logic [9:0] IDX_BOOST_LIMIT = 10'h02B;
   localparam logic [9:0] IDX_FAULT_CONTROL = 10'h02C;
   localparam logic [9:0] IDX_FAULT_TIMEOUT_ONE = 10'h02D;
   localparam logic [9:0] IDX_FAULT_TIMEOUT_TWO = 10'h02E;
   localparam logic [9:0] IDX_FAULT_RECOVERY = 10'h032;
   localparam logic [9:0] IDX_FAULT_STATE = 10'h040;
   localparam logic [9:0] IDX_IRQ_STATUS = 10'h041;
   localparam logic [9:0] IDX_IRQ_MASK = 10'h042;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_SPREAD_SPECTRUM = 8'h00;
   localparam logic [7:0] RST_INPUT_MIX_MUTE = 8'h00;
   localparam logic [7:0] RST_BOOST_LIMIT = 8'h03;
   localparam logic [7:0] RST_FAULT_CONTROL = 8'h00;
   localparam logic [7:0] RST_FAULT_TIMEOUT_ONE = 8'h17;
   localparam logic [7:0] RST_FAULT_TIMEOUT_TWO = 8'h00;
   localparam logic [7:0] RST_FAULT_RECOVERY = 8'h00;
   localparam logic [2:0] RST_IRQ = 3'h0;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int SPREAD_ON_BIT = 0;
   localparam int MUTE_SS_BIT = 0;
   localparam int FIRST_CH_LSB = 1;
   localparam int SECOND_CH_LSB = 3;
   localparam int BOOST_LIM_LSB = 0;
   localparam int TWO_ENABLE_BIT = 0;
   localparam int ONE_ENABLE_BIT = 1;
   localparam int TWO_CLK_SEL_LSB = 2;
   localparam int ONE_CLK_SEL_BIT = 4;
   localparam int ONE_MUTE_METHOD_BIT = 5;
   localparam int TIMEOUT_LSB = 0;
   localparam int ONE_RECOVERY_OFF_BIT = 0;
   localparam int TWO_RECOVERY_OFF_BIT = 1;
   // interrupt status / mask layout
   localparam int IRQ_FAULT_ONE_BIT = 0;
   localparam int IRQ_FAULT_TWO_BIT = 1;
   localparam int IRQ_RECOVER_BIT = 2;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int unsigned SYS_CLK_HZ = 25_000_000;
   localparam int unsigned CYC_PER_US = SYS_CLK_HZ / 1_000_000;
   localparam int TIMER_W = 26;
   // missing-clock timeouts in microseconds, codes 0 to 7
   localparam int unsigned TIMEOUT_US [8] = '{
      2730, 22000, 44000, 87000, 174000, 350000, 700000, 1400000};

   function automatic int unsigned us_to_cycles(input int unsigned us);
      return us * CYC_PER_US;
   endfunction

   localparam int unsigned TIMEOUT_CYC_DEF [8] = '{
      us_to_cycles(TIMEOUT_US[0]), us_to_cycles(TIMEOUT_US[1]),
      us_to_cycles(TIMEOUT_US[2]), us_to_cycles(TIMEOUT_US[3]),
      us_to_cycles(TIMEOUT_US[4]), us_to_cycles(TIMEOUT_US[5]),
      us_to_cycles(TIMEOUT_US[6]), us_to_cycles(TIMEOUT_US[7])};

   // ----------------------------------------------------------------
   // bus responses
   // ----------------------------------------------------------------
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// *** verilog/clock_fault_detector.sv ***
// missing-clock detector: edge watch, timeout counter, fault latch
`timescale 1ns/1ps
module clock_fault_detector (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst,
   // control
   input wire logic i_enable,
   input wire logic i_recovery_off,
   input wire logic [amp_regs_pkg::TIMER_W-1:0] i_limit,
   // watched clock, asynchronous
   input wire logic i_mon_clk,
   // result
   output logic o_fault,
   output logic o_fault_set,
   output logic o_recover
);

   logic mon_meta_q;
   logic mon_sync_q;
   logic mon_prev_q;
   logic mon_edge;
   logic [amp_regs_pkg::TIMER_W-1:0] count_q;
   logic fault_q;

   // ----------------------------------------------------------------
   // synchroniser and edge detect
   // ----------------------------------------------------------------
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         mon_meta_q <= 1'b0;
         mon_sync_q <= 1'b0;
         mon_prev_q <= 1'b0;
      end else begin
         mon_meta_q <= i_mon_clk;
         mon_sync_q <= mon_meta_q;
         mon_prev_q <= mon_sync_q;
      end
   end

   // both edges count, so a clock parked either way still times out
   assign mon_edge = mon_sync_q ^ mon_prev_q;

   // ----------------------------------------------------------------
   // timeout counter
   // ----------------------------------------------------------------
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         count_q <= '0;
      end else if (!i_enable || mon_edge) begin
         count_q <= '0; // [R14]
      end else if (count_q < i_limit) begin
         count_q <= count_q + 1'b1;
      end
   end

   assign o_fault_set = i_enable && !fault_q && !mon_edge &&
      (count_q >= i_limit); // [R14]
   assign o_recover = fault_q && i_enable && mon_edge &&
      !i_recovery_off; // [R13]

   // ----------------------------------------------------------------
   // fault latch
   // ----------------------------------------------------------------
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         fault_q <= 1'b0;
      end else if (!i_enable) begin
         fault_q <= 1'b0;
      end else if (o_fault_set) begin
         fault_q <= 1'b1;
      end else if (o_recover) begin
         fault_q <= 1'b0; // [R13]
      end
   end

   assign o_fault = fault_q;

endmodule // clock_fault_detector

// *** dv/amp_control_clock_fault_regs_props.sv ***
// bus handshake and fault output checker for the amp control bank
`timescale 1ns/1ps
module amp_control_clock_fault_regs_props (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst,
   // bus
   input wire logic i_awvalid,
   input wire logic o_awready,
   input wire logic i_wvalid,
   input wire logic o_wready,
   input wire logic o_bvalid,
   input wire logic i_bready,
   input wire logic [1:0] o_bresp,
   input wire logic i_arvalid,
   input wire logic o_arready,
   input wire logic o_rvalid,
   input wire logic i_rready,
   input wire logic [31:0] o_rdata,
   // audio and fault
   input wire logic i_ramp_clk_internal,
   input wire logic o_spread_spectrum_on,
   input wire logic o_hw_mute_seq,
   input wire logic o_dsp_mute_seq,
   input wire logic o_shutdown,
   input wire logic o_power_fault_flag
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);
   // ----
   // write takes both halves, answer two edges later
   // ----
   sequence s_wr_take;
      i_awvalid && o_awready && i_wvalid && o_wready;
   endsequence
   sequence s_wr_resp;
      ##2 o_bvalid;
   endsequence
   chk_write_resp: assert property (s_wr_take |-> s_wr_resp)
      else $error("write response late");
   chk_b_hold: assert property (o_bvalid && !i_bready |=>
      o_bvalid && $stable(o_bresp)) else $error("write response dropped");
   chk_ready_block: assert property (o_bvalid |-> !o_awready && !o_wready)
      else $error("write taken while response pending");
   chk_read_resp: assert property (i_arvalid && o_arready |=> o_rvalid)
      else $error("read answer late");
   chk_r_hold: assert property (o_rvalid && !i_rready |=>
      o_rvalid && $stable(o_rdata)) else $error("read data dropped");
   chk_spread_gate: assert property (
      !i_ramp_clk_internal |=> !o_spread_spectrum_on)
      else $error("spreading without internal ramp clock");
   chk_mute_excl: assert property (
      !(o_hw_mute_seq && o_dsp_mute_seq)) else $error("both mute kinds");
   chk_mute_shut: assert property (
      o_hw_mute_seq || o_dsp_mute_seq |=> o_shutdown)
      else $error("fault without shutdown");
   chk_power_pair: assert property (
      $fell(o_power_fault_flag) |-> $past(!o_hw_mute_seq && !o_dsp_mute_seq))
      else $error("power fault fell during fault");
endmodule // amp_control_clock_fault_regs_props

bind amp_control_clock_fault_regs amp_control_clock_fault_regs_props i_chk (
   .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_awvalid(i_awvalid),
   .o_awready(o_awready), .i_wvalid(i_wvalid), .o_wready(o_wready),
   .o_bvalid(o_bvalid), .i_bready(i_bready), .o_bresp(o_bresp),
   .i_arvalid(i_arvalid), .o_arready(o_arready), .o_rvalid(o_rvalid),
   .i_rready(i_rready), .o_rdata(o_rdata),
   .i_ramp_clk_internal(i_ramp_clk_internal),
   .o_spread_spectrum_on(o_spread_spectrum_on),
   .o_hw_mute_seq(o_hw_mute_seq), .o_dsp_mute_seq(o_dsp_mute_seq),
   .o_shutdown(o_shutdown), .o_power_fault_flag(o_power_fault_flag));

// *** dv/amp_control_clock_fault_regs_tb.sv ***
// self-checking bench for the amp control register bank
`timescale 1ns/1ps
module amp_control_clock_fault_regs_tb;
   logic i_sys_clk = 0, i_rst = 1, i_ramp_clk_internal = 0;
   logic i_awvalid = 0, i_wvalid = 0, i_bready = 0;
   logic i_arvalid = 0, i_rready = 0;
   logic [11:0] i_awaddr = 0, i_araddr = 0;
   logic [2:0] i_awprot = 0, i_arprot = 0;
   logic [31:0] i_wdata = 0, r;
   logic [3:0] i_wstrb = 0;
   logic [4:0] mon = 0, tog = 0;
   wire i_first_serial_input_clk = mon[0];
   wire i_second_serial_input_clk = mon[1];
   wire i_dac_mod_clk = mon[2];
   wire i_adc_mod_clk = mon[3];
   wire i_pll_clk = mon[4];
   logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq;
   logic o_spread_spectrum_on, o_mute_soft_step_on, o_processor_reset_mode;
   logic o_hw_mute_seq, o_dsp_mute_seq, o_shutdown, o_power_fault_flag;
   logic [1:0] o_bresp, o_rresp, o_boost_current_limit;
   logic [1:0] o_first_input_channel_sel, o_second_input_channel_sel;
   logic [31:0] o_rdata;
   logic [11:0] ra[8] = '{12'h0A0, 12'h0A8, 12'h0AC, 12'h0B0,
      12'h0B4, 12'h0B8, 12'h0C8, 12'h108};
   logic [7:0] rv[8] = '{8'h00, 8'h00, 8'h03, 8'h00,
      8'h17, 8'h00, 8'h00, 8'h00};
   logic [33:0] rq[$];
   logic [1:0] bq[$];
   int num_errors = 0, total_checks = 0, seed = 99, k;

   // short limits keep the missing-clock waits to tens of cycles
   amp_control_clock_fault_regs #(
      .TIMEOUT_CYC('{20, 40, 60, 80, 100, 120, 140, 160})) i_dut (.*);

   always #20 i_sys_clk = ~i_sys_clk;
   always #110 mon = mon ^ tog;
   task automatic ck(input logic [33:0] g, input logic [33:0] e);
      total_checks++;
      if (g !== e) begin
         num_errors++;
         $display("Error t=%0t got %h exp %h", $time, g, e);
      end
   endtask

   // queued results compared as answers appear
   always @(negedge i_sys_clk) begin
      if (o_rvalid && i_rready) ck({o_rresp, o_rdata}, rq.pop_front());
      if (o_bvalid && i_bready) ck(o_bresp, bq.pop_front());
   end

   task automatic wr(input logic [11:0] a, input logic [7:0] d,
      input logic [1:0] e = 2'h0, input logic [3:0] s = 4'hF);
      logic ta, tw, tb;
      bq.push_back(e);
      @(posedge i_sys_clk);
      i_awvalid <= 1;
      i_wvalid <= 1;
      i_awaddr <= a;
      i_wdata <= {24'h000000, d};
      i_wstrb <= s;
      i_bready <= 1;
      do begin
         @(negedge i_sys_clk);
         ta = i_awvalid && o_awready;
         tw = i_wvalid && o_wready;
         tb = o_bvalid;
         @(posedge i_sys_clk);
         if (ta) i_awvalid <= 0;
         if (tw) i_wvalid <= 0;
      end while (!tb);
      i_bready <= 0;
   endtask

   task automatic rd(input logic [11:0] a, input logic [7:0] d,
      input logic [1:0] e = 2'h0);
      logic ta, tr;
      rq.push_back({e, 24'h000000, d});
      @(posedge i_sys_clk);
      i_arvalid <= 1;
      i_araddr <= a;
      i_rready <= 1;
      do begin
         @(negedge i_sys_clk);
         ta = i_arvalid && o_arready;
         tr = o_rvalid;
         @(posedge i_sys_clk);
         if (ta) i_arvalid <= 0;
      end while (!tr);
      i_rready <= 0;
   endtask

   task automatic cy(input int n);
      repeat (n) @(negedge i_sys_clk);
   endtask

   task automatic ws(input logic v);
      int n;
      n = 0;
      while (o_shutdown !== v && n < 200) begin
         @(negedge i_sys_clk);
         n++;
      end
      ck(o_shutdown, v);
   endtask

   task automatic finish_test;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   initial begin
      #400000;
      num_errors++;
      finish_test;
   end

   initial begin
      repeat (4) @(posedge i_sys_clk);
      i_rst <= 0;
      cy(1);
      ck(o_mute_soft_step_on, 1'b1);
      for (k = 0; k < 8; k++) rd(ra[k], rv[k]);
      rd(12'h0F0, 8'h00, 2'h2);
      wr(12'h0F0, 8'h55, 2'h2);
      for (k = 0; k < 4; k++) begin
         r = $random(seed);
         wr(12'h0A8, {r[7:5], k[1:0], ~k[1:0], r[0]});
         wr(12'h0AC, {r[7:2], k[1:0]});
         cy(2);
         ck(o_second_input_channel_sel, k[1:0]);
         ck(o_first_input_channel_sel, 2'(~k[1:0]));
         ck(o_mute_soft_step_on, !r[0]);
         ck(o_boost_current_limit, k[1:0]);
         rd(12'h0A8, {r[7:5], k[1:0], ~k[1:0], r[0]});
      end
      wr(12'h0AC, 8'h00, 2'h0, 4'h0);
      rd(12'h0AC, {r[7:2], 2'h3});
      wr(12'h0A0, 8'h01);
      @(posedge i_sys_clk) i_ramp_clk_internal <= 1;
      cy(2);
      ck(o_spread_spectrum_on, 1'b1);
      @(posedge i_sys_clk) i_ramp_clk_internal <= 0;
      cy(2);
      ck(o_spread_spectrum_on, 1'b0);
      // block one: hardware mute, then processor mute with no recovery
      wr(12'h0B4, 8'h00);
      wr(12'h108, 8'h01);
      tog = 5'h01;
      wr(12'h0B0, 8'h02);
      cy(80);
      ck(o_shutdown, 1'b0);
      tog = 5'h02;
      ws(1);
      ck(o_hw_mute_seq, 1'b1);
      ck(o_irq, 1'b1);
      rd(12'h104, 8'h01);
      tog = 5'h01;
      ws(0);
      rd(12'h104, 8'h05);
      wr(12'h104, 8'h05);
      cy(2);
      ck(o_irq, 1'b0);
      wr(12'h0C8, 8'h01);
      tog = 5'h02;
      wr(12'h0B0, 8'h32);
      cy(80);
      ck(o_shutdown, 1'b0);
      tog = 5'h00;
      ws(1);
      ck(o_dsp_mute_seq, 1'b1);
      tog = 5'h02;
      cy(60);
      ck(o_shutdown, 1'b1);
      wr(12'h0B0, 8'h00);
      ws(0);
      wr(12'h104, 8'h07);
      // block two over its three clocks, its interrupt masked
      for (k = 0; k < 3; k++) begin
         tog = 5'h04 << k;
         wr(12'h0B0, {4'h0, k[1:0], 2'h1});
         cy(80);
         ck(o_shutdown, 1'b0);
         tog = 5'h1C ^ (5'h04 << k);
         ws(1);
         ck(o_irq, 1'b0);
         wr(12'h0B0, 8'h00);
         ws(0);
      end
      tog = 5'h00;
      wr(12'h0B0, 8'h8D);
      cy(80);
      ck(o_shutdown, 1'b0);
      ck(o_processor_reset_mode, 1'b1);
      finish_test;
   end
endmodule // amp_control_clock_fault_regs_tb
